//--- core/sea_clk_div.v
// Divider giving the half-period tick of the EEPROM serial clock.
// Assumes one system clock; rate code comes from the control register.
`timescale 1ns/1ps
`default_nettype none
`include "sea_map.vh"

module sea_clk_div #(
  parameter integer DIV_NORMAL = `SEA_DIV_NORMAL,
  parameter integer DIV_TEST   = `SEA_DIV_TEST
) (
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire [1:0] rate_sel,
  output reg        tick_ff
);

  localparam integer HALF_N = DIV_NORMAL / 2;
  localparam integer HALF_T = DIV_TEST / 2;

  reg  [15:0] cnt_ff;
  wire [15:0] half_last;

  // Reserved codes fall back to the normal rate
  assign half_last = (rate_sel == `SEA_RATE_TEST) ? HALF_T[15:0] - 16'h0001 :
                                                    HALF_N[15:0] - 16'h0001;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= half_last) begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- core/sea_ctrl.v
// Serial EEPROM access controller: APB register file, command sequencer,
// configuration autoload and interrupt logic.
// Assumes an APB master on clk_sys and a serial EEPROM on the pins.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sea_map.vh"

module sea_ctrl #(
  parameter [15:0] AUTOLOAD_SIG = 16'h5A5A  // Arbitrary signature value
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq_ff,
  output reg  [31:0] loadcfg_ff,
  output wire        eeprom_sck,
  output wire        eeprom_csn,
  output wire        eeprom_mosi,
  input  wire        eeprom_miso
);

  // --------------------------------------------------------------------
  // States and storage
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_CMD    = 3'h1;
  localparam [2:0] ST_AL_SIG = 3'h2;
  localparam [2:0] ST_AL_LO  = 3'h3;
  localparam [2:0] ST_AL_HI  = 3'h4;

  reg  [2:0]  state_ff;
  reg         start_ff;
  reg  [2:0]  cmd_ff;
  reg         al_ok_ff;
  reg         al_inh_ff;
  reg         al_pend_ff;
  reg  [1:0]  rate_ff;
  reg  [7:0]  stat_ff;
  reg  [15:0] addr_ff;
  reg  [15:0] data_ff;
  reg  [2:0]  irq_stat_ff;
  reg  [2:0]  irq_mask_ff;
  reg         sh_start;
  reg  [45:0] frame;
  reg  [2:0]  ev_set;
  reg  [31:0] rd_mux;
  reg         rd_hit;

  wire        tick;
  wire        sh_busy;
  wire        sh_done;
  wire [15:0] sh_rx;
  wire        acc_wr;
  wire        setup;

  // --------------------------------------------------------------------
  // Frame builder: {bit count, 40-bit frame left aligned}
  // --------------------------------------------------------------------
  function [45:0] build_frame;
    input [2:0]  cmd;
    input [15:0] addr;
    input [15:0] data;
    input [7:0]  stat;
    begin
      case (cmd)
        `SEA_CMD_WRSR:  build_frame = {6'h10, `SEA_OP_WRSR, stat, 24'h000000};
        `SEA_CMD_WRITE: build_frame = {6'h28, `SEA_OP_WRITE, addr, data};
        `SEA_CMD_READ:  build_frame = {6'h28, `SEA_OP_READ, addr, 16'h0000};
        `SEA_CMD_WRDI:  build_frame = {6'h08, `SEA_OP_WRDI, 32'h00000000};
        `SEA_CMD_RDSR:  build_frame = {6'h10, `SEA_OP_RDSR, 32'h00000000};
        `SEA_CMD_WREN:  build_frame = {6'h08, `SEA_OP_WREN, 32'h00000000};
        default:        build_frame = {6'h00, 40'h0000000000};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Serial clock and frame engine
  // --------------------------------------------------------------------
  sea_clk_div u_div (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .rate_sel (rate_ff),
    .tick_ff  (tick)
  );

  sea_shifter u_shift (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tick    (tick),
    .start   (sh_start),
    .nbits   (frame[45:40]),
    .tx_data (frame[39:0]),
    .miso    (eeprom_miso),
    .busy_ff (sh_busy),
    .done_ff (sh_done),
    .rx_ff   (sh_rx),
    .sck_ff  (eeprom_sck),
    .csn_ff  (eeprom_csn),
    .mosi_ff (eeprom_mosi)
  );

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pready & pwrite & ~pslverr;

  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (paddr == `SEA_OFF_CTRL) begin
      rd_mux = {16'h0000, stat_ff, rate_ff, al_inh_ff, al_ok_ff, cmd_ff, start_ff};
    end else if (paddr == `SEA_OFF_ADDR_DATA) begin
      rd_mux = {data_ff, addr_ff};
    end else if (paddr == `SEA_OFF_IRQ_STAT) begin
      rd_mux = {29'h00000000, irq_stat_ff};
    end else if (paddr == `SEA_OFF_IRQ_MASK) begin
      rd_mux = {29'h00000000, irq_mask_ff};
    end else if (paddr == `SEA_OFF_LOADCFG) begin
      rd_mux = loadcfg_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One registered answer cycle: pready rises in the first access cycle
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pready  <= 1'b1;
      pslverr <= ~rd_hit;
    end else begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always @* begin
    sh_start = 1'b0;
    frame    = build_frame(cmd_ff, addr_ff, data_ff, stat_ff);
    case (state_ff)
      ST_AL_SIG: frame = build_frame(`SEA_CMD_READ, `SEA_AL_ADDR_SIG, 16'h0000, 8'h00);
      ST_AL_LO:  frame = build_frame(`SEA_CMD_READ, `SEA_AL_ADDR_LO, 16'h0000, 8'h00);
      ST_AL_HI:  frame = build_frame(`SEA_CMD_READ, `SEA_AL_ADDR_HI, 16'h0000, 8'h00);
      default:   frame = build_frame(cmd_ff, addr_ff, data_ff, stat_ff);
    endcase
    if (state_ff != ST_IDLE && !sh_busy && !sh_done && frame[45:40] != 6'h00) begin
      sh_start = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff   <= ST_IDLE;
      start_ff   <= 1'b0;
      cmd_ff     <= 3'h0;
      al_ok_ff   <= 1'b0;
      al_inh_ff  <= 1'b1;
      al_pend_ff <= 1'b1;
      rate_ff    <= `SEA_RATE_DIV64;
      stat_ff    <= 8'h00;
      addr_ff    <= 16'h0000;
      data_ff    <= 16'h0000;
      loadcfg_ff <= `SEA_LOADCFG_RESET;
      ev_set     <= 3'h0;
    end else begin
      ev_set <= 3'h0;
      // Software writes
      if (acc_wr && paddr == `SEA_OFF_CTRL) begin
        // Command held while a cycle runs, so its completion decode stays valid
        if (state_ff == ST_IDLE) begin
          cmd_ff <= pwdata[`SEA_CMD_MSB:`SEA_CMD_LSB];
        end
        rate_ff   <= pwdata[`SEA_RATE_MSB:`SEA_RATE_LSB];
        al_inh_ff <= pwdata[`SEA_BIT_AL_INH];
        // Only the writable status bits take software data
        stat_ff   <= (stat_ff & ~`SEA_STAT_RW_MASK) |
                     (pwdata[`SEA_STAT_MSB:`SEA_STAT_LSB] & `SEA_STAT_RW_MASK);
        if (pwdata[`SEA_BIT_AL_INH]) begin
          al_pend_ff <= 1'b0;
        end
        if (pwdata[`SEA_BIT_START] && state_ff == ST_IDLE) begin
          start_ff <= 1'b1;
          state_ff <= ST_CMD;
        end
      end
      if (acc_wr && paddr == `SEA_OFF_ADDR_DATA && state_ff == ST_IDLE) begin
        addr_ff <= pwdata[15:0];
        data_ff <= pwdata[31:16];
      end
      if (acc_wr && paddr == `SEA_OFF_LOADCFG) begin
        loadcfg_ff <= pwdata;
      end
      // Autoload launches once, the first time the inhibit is clear, unless a write with the inhibit bit set came first
      // A start landing on the same edge wins; autoload follows once idle
      if (state_ff == ST_IDLE && al_pend_ff && !al_inh_ff &&
          !(acc_wr && paddr == `SEA_OFF_CTRL && pwdata[`SEA_BIT_START])) begin
        al_pend_ff <= 1'b0;
        state_ff   <= ST_AL_SIG;
      end
      case (state_ff)
        ST_CMD: begin
          if (sh_done || frame[45:40] == 6'h00) begin
            start_ff  <= 1'b0;
            state_ff  <= ST_IDLE;
            ev_set[`SEA_IRQ_CMD_DONE] <= 1'b1;
            if (cmd_ff == `SEA_CMD_READ) begin
              data_ff <= sh_rx;
            end
            if (cmd_ff == `SEA_CMD_RDSR) begin
              stat_ff <= sh_rx[7:0];
            end
          end
        end
        ST_AL_SIG: begin
          if (sh_done) begin
            if (sh_rx == AUTOLOAD_SIG) begin
              state_ff <= ST_AL_LO;
            end else begin
              al_ok_ff <= 1'b0;
              state_ff <= ST_IDLE;
              ev_set[`SEA_IRQ_AL_FAIL] <= 1'b1;
            end
          end
        end
        ST_AL_LO: begin
          if (sh_done) begin
            loadcfg_ff[15:0] <= sh_rx;
            state_ff         <= ST_AL_HI;
          end
        end
        ST_AL_HI: begin
          if (sh_done) begin
            loadcfg_ff[31:16] <= sh_rx;
            al_ok_ff          <= 1'b1;
            state_ff          <= ST_IDLE;
            ev_set[`SEA_IRQ_AL_OK] <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  // New events win over a same-cycle write-one-to-clear
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_stat_ff <= 3'h0;
      irq_mask_ff <= 3'h0;
      irq_ff      <= 1'b0;
    end else begin
      if (acc_wr && paddr == `SEA_OFF_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[2:0]) | ev_set;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev_set;
      end
      if (acc_wr && paddr == `SEA_OFF_IRQ_MASK) begin
        irq_mask_ff <= pwdata[2:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

endmodule
`default_nettype wire

//--- core/sea_shifter.v
// Serial frame engine for the EEPROM: chip select, clock, data out/in.
// Assumes a half-period tick; frame is MSB first, sampled on rising clock.
`timescale 1ns/1ps
`default_nettype none

module sea_shifter #(
  parameter integer FRAME_W = 40,
  parameter integer RX_W    = 16
) (
  input  wire               clk_sys,
  input  wire               resetn,
  input  wire               tick,
  input  wire               start,
  input  wire [5:0]         nbits,
  input  wire [FRAME_W-1:0] tx_data,
  input  wire               miso,
  output reg                busy_ff,
  output reg                done_ff,
  output reg  [RX_W-1:0]    rx_ff,
  output reg                sck_ff,
  output reg                csn_ff,
  output reg                mosi_ff
);

  reg [FRAME_W-1:0] sh_ff;
  reg [5:0]         cnt_ff;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sh_ff   <= {FRAME_W{1'b0}};
      cnt_ff  <= 6'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rx_ff   <= {RX_W{1'b0}};
      sck_ff  <= 1'b0;
      csn_ff  <= 1'b1;
      mosi_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!busy_ff) begin
        if (start) begin
          sh_ff   <= tx_data;
          cnt_ff  <= nbits;
          busy_ff <= 1'b1;
          csn_ff  <= 1'b0;
          mosi_ff <= tx_data[FRAME_W-1];
          rx_ff   <= {RX_W{1'b0}};
        end
      end else if (tick) begin
        if (!sck_ff) begin
          sck_ff <= 1'b1;
          rx_ff  <= {rx_ff[RX_W-2:0], miso};
          cnt_ff <= cnt_ff - 6'h01;
        end else begin
          sck_ff <= 1'b0;
          if (cnt_ff == 6'h00) begin
            // Chip select rises on the same edge as the last falling clock edge
            csn_ff  <= 1'b1;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            mosi_ff <= 1'b0;
          end else begin
            sh_ff   <= {sh_ff[FRAME_W-2:0], 1'b0};
            mosi_ff <= sh_ff[FRAME_W-2];
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- inc/sea_map.vh
// Register map, field positions, reset values and timing counts of the
// serial EEPROM access controller. Definitions only.
`ifndef SEA_MAP_VH
`define SEA_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SEA_OFF_CTRL      8'hA0
`define SEA_OFF_ADDR_DATA 8'hA4
`define SEA_OFF_IRQ_STAT  8'hC0
`define SEA_OFF_IRQ_MASK  8'hC4
`define SEA_OFF_LOADCFG   8'hC8

// ----------------------------------------------------------------------
// Command and status register fields
// ----------------------------------------------------------------------
`define SEA_BIT_START     0
`define SEA_CMD_LSB       1
`define SEA_CMD_MSB       3
`define SEA_BIT_AL_OK     4
`define SEA_BIT_AL_INH    5
`define SEA_RATE_LSB      6
`define SEA_RATE_MSB      7
`define SEA_STAT_LSB      8
`define SEA_STAT_MSB      15
`define SEA_STAT_RW_MASK  8'h8C
`define SEA_CTRL_RESET    16'h0060

// ----------------------------------------------------------------------
// Command encodings and EEPROM opcodes
// ----------------------------------------------------------------------
`define SEA_CMD_WRSR      3'h1
`define SEA_CMD_WRITE     3'h2
`define SEA_CMD_READ      3'h3
`define SEA_CMD_WRDI      3'h4
`define SEA_CMD_RDSR      3'h5
`define SEA_CMD_WREN      3'h6
`define SEA_OP_WRSR       8'h01
`define SEA_OP_WRITE      8'h02
`define SEA_OP_READ       8'h03
`define SEA_OP_WRDI       8'h04
`define SEA_OP_RDSR       8'h05
`define SEA_OP_WREN       8'h06

// ----------------------------------------------------------------------
// Clock rate codes and divider counts
// ----------------------------------------------------------------------
`define SEA_RATE_DIV64    2'h1
`define SEA_RATE_TEST     2'h3
`define SEA_DIV_NORMAL    64
`define SEA_DIV_TEST      2

// ----------------------------------------------------------------------
// Interrupt status bits and autoload layout
// ----------------------------------------------------------------------
`define SEA_IRQ_CMD_DONE  0
`define SEA_IRQ_AL_OK     1
`define SEA_IRQ_AL_FAIL   2
`define SEA_AL_ADDR_SIG   16'h0000
`define SEA_AL_ADDR_LO    16'h0001
`define SEA_AL_ADDR_HI    16'h0002
`define SEA_LOADCFG_RESET 32'h0000_0000

`endif

//--- test/sea_ctrl_sva.sv
// Checker on the controller pins: APB answer and EEPROM framing.
// Assumes one clock domain and the register map header.
`timescale 1ns/1ps
`default_nettype none
`include "sea_map.vh"
module sea_ctrl_sva (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_ff,
  input wire logic [31:0] loadcfg_ff,
  input wire logic        eeprom_sck,
  input wire logic        eeprom_csn,
  input wire logic        eeprom_mosi
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic mapped = paddr inside {`SEA_OFF_CTRL, `SEA_OFF_ADDR_DATA,
    `SEA_OFF_IRQ_STAT, `SEA_OFF_IRQ_MASK, `SEA_OFF_LOADCFG};
  pready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  err_unmapped_a: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  rdata_quiet_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  sck_idle_a: assert property (eeprom_csn |-> !eeprom_sck)
    else $error("serial clock runs while deselected");
  reset_idle_a: assert property ($rose(resetn) |-> eeprom_csn && !irq_ff
    && loadcfg_ff == 32'h0) else $error("outputs not idle after reset");
  frame_start_a: assert property (psel && penable && pready && pwrite
    && paddr == `SEA_OFF_CTRL && pwdata[0] && pwdata[3:1] inside {[3'h1:3'h6]}
    && eeprom_csn |-> ##[1:4] !eeprom_csn) else $error("start gave no frame");
  mosi_fall_a: assert property (!eeprom_csn && !$fell(eeprom_csn)
    && $changed(eeprom_mosi) |-> $fell(eeprom_sck))
    else $error("serial data moved off falling clock");
endmodule
bind sea_ctrl sea_ctrl_sva i_sea_ctrl_sva (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_ff(irq_ff),
  .loadcfg_ff(loadcfg_ff), .eeprom_sck(eeprom_sck), .eeprom_csn(eeprom_csn),
  .eeprom_mosi(eeprom_mosi));
`default_nettype wire

//--- test/sea_eeprom_model.sv
// Behavioural serial EEPROM facing the controller pins.
// Assumes mode 0 framing, MSB first, one 16-bit word per address.
`timescale 1ns/1ps
`default_nettype none
module sea_eeprom_model #(
  parameter int WIP_NS = 30000
) (
  input  wire logic sck,
  input  wire logic csn,
  input  wire logic mosi,
  output wire logic miso
);
  logic [15:0] mem [0:255];
  logic [39:0] sh_ff;
  logic [15:0] out_ff = 16'h0000;
  logic [7:0]  sr_ff = 8'h00;
  logic        drv_ff = 1'b0;
  int          cnt = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
  // Deselected line shows the inverse of the last driven bit
  assign miso = csn ? ~drv_ff : drv_ff;
  always @(negedge csn) cnt = 0;
  always @(posedge sck) if (!csn) begin
    sh_ff = {sh_ff[38:0], mosi};
    cnt = cnt + 1;
    if (cnt == 8 && sh_ff[7:0] == 8'h05) out_ff = {sr_ff, 8'h00};
    if (cnt == 24 && sh_ff[23:16] == 8'h03) out_ff = mem[sh_ff[7:0]];
  end
  always @(negedge sck) if (!csn) begin
    drv_ff = out_ff[15];
    out_ff = {out_ff[14:0], 1'b0};
  end
  always @(posedge csn) begin
    if (cnt == 8 && sh_ff[7:0] == 8'h06) sr_ff[1] = 1'b1;
    if (cnt == 8 && sh_ff[7:0] == 8'h04) sr_ff[1] = 1'b0;
    if (cnt == 16 && sh_ff[15:8] == 8'h01 && sr_ff[1])
      sr_ff = {sh_ff[7], sr_ff[6:4], sh_ff[3:2], 2'b00};
    if (cnt == 40 && sh_ff[39:32] == 8'h02 && sr_ff[1]) begin
      mem[sh_ff[23:16]] = sh_ff[15:0];
      sr_ff[1] = 1'b0;
      sr_ff[0] = 1'b1;
    end
  end
  // Write cycle time, long enough for several status polls
  always @(posedge sr_ff[0]) begin
    #(WIP_NS);
    sr_ff[0] = 1'b0;
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the serial EEPROM access controller.
// Assumes the EEPROM model on the pins; APB is driven from here.
`timescale 1ns/1ps
`default_nettype none
`include "sea_map.vh"
module tb_top;
  localparam logic [15:0] SIG = 16'hC3A5; // Arbitrary signature value
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } sea_row_t;
  logic        clk_sys, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, loadcfg_ff, rdat;
  logic        pready, pslverr, irq_ff, rerr;
  logic        eeprom_sck, eeprom_csn, eeprom_mosi, eeprom_miso;
  int          err_count = 0, checked = 0, cyc = 0;
  sea_row_t    rows [12] = '{
    '{1'b0, `SEA_OFF_CTRL, 32'h0, 32'h0000_0060, 1'b0},
    '{1'b0, `SEA_OFF_ADDR_DATA, 32'h0, 32'h0, 1'b0},
    '{1'b0, `SEA_OFF_LOADCFG, 32'h0, 32'h0, 1'b0},
    '{1'b0, `SEA_OFF_IRQ_MASK, 32'h0, 32'h0, 1'b0},
    '{1'b1, `SEA_OFF_ADDR_DATA, 32'h1234_ABCD, 32'h0, 1'b0},
    '{1'b0, `SEA_OFF_ADDR_DATA, 32'h0, 32'h1234_ABCD, 1'b0},
    '{1'b1, `SEA_OFF_CTRL, 32'hFFFF_FFF0, 32'h0, 1'b0},
    '{1'b0, `SEA_OFF_CTRL, 32'h0, 32'h0000_8CE0, 1'b0},
    '{1'b1, `SEA_OFF_LOADCFG, 32'hA5A5_0F0F, 32'h0, 1'b0},
    '{1'b0, `SEA_OFF_LOADCFG, 32'h0, 32'hA5A5_0F0F, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h10, 32'h0, 32'h0, 1'b1}
  };
  sea_ctrl #(.AUTOLOAD_SIG(SIG)) i_sea_ctrl (.clk_sys(clk_sys), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_ff(irq_ff),
    .loadcfg_ff(loadcfg_ff), .eeprom_sck(eeprom_sck), .eeprom_csn(eeprom_csn),
    .eeprom_mosi(eeprom_mosi), .eeprom_miso(eeprom_miso));
  sea_eeprom_model i_sea_eeprom_model (.sck(eeprom_sck), .csn(eeprom_csn),
    .mosi(eeprom_mosi), .miso(eeprom_miso));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Reads pready before this edge's updates land, so no race
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, rdat, rerr);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    rd(a);
    for (int n = 0; n < 500 && rdat[b] !== v; n++) rd(a);
  endtask
  // Fast test rate, autoload kept inhibited
  task automatic run(input logic [2:0] c, input logic [7:0] st);
    wr(`SEA_OFF_CTRL, {16'h0, st, 4'hE, c, 1'b1});
    poll(`SEA_OFF_CTRL, 0, 1'b0);
    chk("start_clear", rdat & 32'h1, 32'h0);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rdat, rerr);
      if (!rows[i].w) chk("row_rdata", rdat, rows[i].r);
      chk("row_err", {31'h0, rerr}, {31'h0, rows[i].e});
    end
    run(`SEA_CMD_WREN, 8'h00);
    run(`SEA_CMD_RDSR, 8'h00);
    chk("wel_set", rdat & 32'hFF00, 32'h0200);
    wr(`SEA_OFF_ADDR_DATA, 32'hBEEF_0005);
    run(`SEA_CMD_WRITE, 8'h00);
    run(`SEA_CMD_RDSR, 8'h00);
    chk("wip_set", rdat & 32'hFF00, 32'h0100);
    for (int n = 0; n < 30 && rdat[8] !== 1'b0; n++) run(`SEA_CMD_RDSR, 8'h00);
    chk("wip_clear", rdat & 32'hFF00, 32'h0);
    wr(`SEA_OFF_ADDR_DATA, 32'h0000_0005);
    run(`SEA_CMD_READ, 8'h00);
    rd(`SEA_OFF_ADDR_DATA);
    chk("read_data", rdat, 32'hBEEF_0005);
    run(`SEA_CMD_WREN, 8'h00);
    run(`SEA_CMD_WRSR, 8'h8C);
    run(`SEA_CMD_RDSR, 8'h00);
    chk("stat_write", rdat & 32'hFF00, 32'h8C00);
    run(`SEA_CMD_WREN, 8'h00);
    run(`SEA_CMD_WRDI, 8'h00);
    run(`SEA_CMD_RDSR, 8'h00);
    chk("wel_clear", rdat & 32'hFF00, 32'h8C00);
    wr(`SEA_OFF_IRQ_STAT, 32'h7);
    wr(`SEA_OFF_IRQ_MASK, 32'h1);
    run(3'h0, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("irq_on", {31'h0, irq_ff}, 32'h1);
    wr(`SEA_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq_off", {31'h0, irq_ff}, 32'h0);
    wr(`SEA_OFF_IRQ_MASK, 32'h0);
    run(3'h7, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("irq_masked", {31'h0, irq_ff}, 32'h0);
    rd(`SEA_OFF_IRQ_STAT);
    chk("irq_stat", rdat, 32'h1);
    // Slow rate: second start and address write land mid-frame
    wr(`SEA_OFF_CTRL, 32'h0000_006D);
    wr(`SEA_OFF_ADDR_DATA, 32'h5555_5555);
    wr(`SEA_OFF_CTRL, 32'h0000_0065);
    rd(`SEA_OFF_CTRL);
    chk("busy_start", rdat & 32'h1, 32'h1);
    rd(`SEA_OFF_ADDR_DATA);
    chk("busy_addr", rdat, 32'hBEEF_0005);
    poll(`SEA_OFF_CTRL, 0, 1'b0);
    run(`SEA_CMD_RDSR, 8'h00);
    chk("busy_ignored", rdat & 32'hFF00, 32'h8E00);
    i_sea_eeprom_model.mem[0] = SIG;
    i_sea_eeprom_model.mem[1] = 16'h1357;
    i_sea_eeprom_model.mem[2] = 16'h2468;
    do_reset();
    repeat (100) @(posedge clk_sys);
    chk("al_held", loadcfg_ff, 32'h0);
    wr(`SEA_OFF_CTRL, 32'h0000_00C0);
    poll(`SEA_OFF_CTRL, 4, 1'b1);
    chk("al_ok", rdat & 32'h10, 32'h10);
    chk("al_cfg", loadcfg_ff, 32'h2468_1357);
    rd(`SEA_OFF_IRQ_STAT);
    chk("al_event", rdat, 32'h2);
    i_sea_eeprom_model.mem[0] = ~SIG;
    do_reset();
    wr(`SEA_OFF_CTRL, 32'h0000_00C0);
    poll(`SEA_OFF_IRQ_STAT, 2, 1'b1);
    chk("al_fail", rdat, 32'h4);
    rd(`SEA_OFF_CTRL);
    chk("al_bit", rdat & 32'h10, 32'h0);
    chk("al_keep", loadcfg_ff, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
